/* bench/iad_decode_sva.sv */
// Checker for the address decode front end.
// Assumes straps stay put while bus traffic runs.
`timescale 1ns/1ps
`default_nettype none
module iad_decode_sva
  import iad_pkg::*;
#(
  parameter int NREG = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire iad_isa_pins_t isa_in,
  input wire iad_cfg_t straps,
  input wire logic [7:0] port_c,
  input wire logic ana_irq_req,
  input wire logic dio_irq_req,
  input wire logic [NSTREAM-1:0] dma_req,
  input wire iad_access_t access,
  input wire logic [NSTREAM-1:0] dma_ack,
  input wire logic [NCHAN-1:0] drq_out,
  input wire logic [NCHAN-1:0] drq_oe,
  input wire logic [IRQ_W-1:0] irq_out,
  input wire logic [IRQ_W-1:0] irq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_rd_edge: assert property (
    access.rd_stb |-> !$past(isa_in.iord_n, 3) && $past(isa_in.iord_n, 4)) else $error("rd edge");
  a_hit_base: assert property (
    access.rd_stb | access.wr_stb |-> $past(isa_in.addr[9:5], 3) == straps.base_address_switch)
    else $error("base");
  a_reg_index: assert property (
    access.rd_stb | access.wr_stb |-> access.reg_index == $past(isa_in.addr[4:0], 3))
    else $error("index");
  a_cpu_only: assert property (
    access.wr_stb | access.rd_stb |-> !$past(isa_in.aen, 3) && $past(isa_in.dack_n, 3) == 3'h7)
    else $error("dma cycle hit");
  a_pulse_one: assert property (
    access.rd_stb | access.wr_stb |=> !(access.rd_stb | access.wr_stb)) else $error("pulse");
  a_ana_irq: assert property (
    ana_irq_req && straps.ana_irq_jumper == 4'hA && straps == $past(straps, 3)
    |=> irq_oe[10] && irq_out[10]) else $error("ana irq");
  a_dio_gate: assert property (
    straps.dio_irq_jumper == 4'h5 && straps.ana_irq_jumper != 4'h5 && straps == $past(straps, 3)
    && !port_c[straps.dio_irq_gate_jumper] |=> !irq_oe[5]) else $error("dio gate");
  a_dma_ack: assert property (
    dma_ack[0] |-> !$past(isa_in.dack_n[straps.dma_route_jumpers[0] - 2'h1], 3))
    else $error("dma ack");
endmodule
bind iad_decode iad_decode_sva #(.NREG(NREG)) i_iad_decode_sva (.clk_sys(clk_sys),
  .nrst(nrst), .ce(ce), .isa_in(isa_in), .straps(straps), .port_c(port_c),
  .ana_irq_req(ana_irq_req), .dio_irq_req(dio_irq_req), .dma_req(dma_req), .access(access),
  .dma_ack(dma_ack), .drq_out(drq_out), .drq_oe(drq_oe), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire

/* bench/iad_decode_tb.sv */
// Self-checking bench for the address decode front end.
// Assumes the host model drives the bus pins; bench drives straps and requests.
`timescale 1ns/1ps
`default_nettype none
module iad_decode_tb;
  import iad_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  iad_isa_pins_t isa_in;
  iad_cfg_t straps;
  logic [7:0] port_c = 8'h00;
  logic ana_irq_req = 1'b0;
  logic dio_irq_req = 1'b0;
  logic [1:0] dma_req = 2'h0;
  iad_access_t access;
  logic [1:0] dma_ack;
  logic [2:0] drq_out, drq_oe, ex;
  logic [15:0] irq_out, irq_oe, eo;
  int fails = 0;
  int n_checks = 0;
  int nrd = 0;
  int nwr = 0;
  logic [31:0] rs = 32'h0000_000E;
  initial straps = {DEF_BASE_SW, DEF_DMA2, DEF_DMA1, DEF_ANA_IRQ, DEF_DIO_IRQ, DEF_GATE_BIT};
  initial forever #12.5 clk_sys = ~clk_sys;
  iad_host_model i_iad_host_model (.clk_sys(clk_sys), .pins(isa_in));
  iad_decode i_iad_decode (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .isa_in(isa_in),
    .straps(straps), .port_c(port_c), .ana_irq_req(ana_irq_req), .dio_irq_req(dio_irq_req),
    .dma_req(dma_req), .access(access), .dma_ack(dma_ack), .drq_out(drq_out),
    .drq_oe(drq_oe), .irq_out(irq_out), .irq_oe(irq_oe));
  always @(posedge clk_sys) begin
    if (access.rd_stb === 1'b1) nrd++;
    if (access.wr_stb === 1'b1) nwr++;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic acc(logic [9:0] a, logic rd, logic aen, logic [2:0] dk);
    int r0 = nrd;
    int w0 = nwr;
    logic hit = a[9:5] === straps.base_address_switch && !aen && dk === 3'h7;
    i_iad_host_model.io_cycle(a, rd, aen, dk);
    check("rd", 16'(nrd - r0), 16'(hit && rd));
    check("wr", 16'(nwr - w0), 16'(hit && !rd));
    // Select still shows the cycle's match: it lags the released address by three edges
    check("sel", 16'(access.sel), 16'(hit));
    if (hit) check("idx", 16'(access.reg_index), 16'(a[4:0]));
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    acc(10'h220, 1'b1, 1'b0, 3'h7);
    acc(10'h23F, 1'b0, 1'b0, 3'h7);
    acc(10'h21F, 1'b1, 1'b0, 3'h7);
    acc(10'h240, 1'b0, 1'b0, 3'h7);
    acc(10'h223, 1'b1, 1'b1, 3'h7);
    acc(10'h223, 1'b0, 1'b0, 3'h5);
    $display("window test done");
    for (int i = 0; i < 40; i++) begin
      straps.base_address_switch = 5'(rnd());
      repeat (3) @(negedge clk_sys);
      acc({rnd() % 2 ? straps.base_address_switch : 5'(rnd()), 5'(rnd())}, rnd() % 2 == 1,
        rnd() % 5 == 0, rnd() % 5 == 0 ? 3'(rnd()) : 3'h7);
    end
    $display("random test done");
    for (int c = 0; c < 8; c++) begin
      straps.dma_route_jumpers = 4'(c[1:0]) << (2 * c[2]);
      dma_req = 2'(1) << c[2];
      ex = c[1:0] != 2'h0 ? 3'(1) << (c[1:0] - 2'h1) : 3'h0;
      repeat (4) @(negedge clk_sys);
      check("drq", 16'(drq_out & drq_oe), 16'(ex));
      i_iad_host_model.io_cycle(10'h000, 1'b1, 1'b1, ~ex);
      // The acknowledge was just released; the stream's flag lags it by three edges
      check("ack", 16'(dma_ack), 16'(ex != 3'h0) << c[2]);
    end
    $display("dma test done");
    for (int l = 0; l < 16; l++) begin
      straps.ana_irq_jumper = 4'(l);
      straps.dio_irq_jumper = 4'(l);
      straps.dio_irq_gate_jumper = 3'(l);
      port_c = 8'(rnd());
      ana_irq_req = rnd() % 2 == 1;
      dio_irq_req = rnd() % 2 == 1;
      eo = 16'(ANA_IRQ_OK[l] | (DIO_IRQ_OK[l] & port_c[l % 8])) << l;
      repeat (4) @(negedge clk_sys);
      check("irq_oe", irq_oe, eo);
      ex = 3'((ANA_IRQ_OK[l] & ana_irq_req) | (DIO_IRQ_OK[l] & port_c[l % 8] & dio_irq_req));
      check("irq_out", irq_out & irq_oe, 16'(ex[0]) << l);
    end
    $display("irq test done");
    stop_test();
  end
endmodule
`default_nettype wire

/* bench/iad_host_model.sv */
// Host bus model: processor I/O cycles and DMA acknowledges.
// Assumes callers step it from the bench; pins change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module iad_host_model
  import iad_pkg::*;
(
  input wire logic clk_sys,
  output iad_isa_pins_t pins
);
  initial pins = {10'h000, 1'b1, 1'b1, 1'b0, 3'h7};
  task automatic io_cycle(logic [9:0] a, logic rd, logic aen, logic [2:0] dk);
    @(negedge clk_sys);
    pins.addr = a;
    pins.aen = aen;
    pins.dack_n = dk;
    @(negedge clk_sys);
    if (rd) pins.iord_n = 1'b0;
    else pins.iowr_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    pins.iord_n = 1'b1;
    pins.iowr_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // Released address lines must not keep the old value
    pins.addr = ~a;
    pins.dack_n = 3'h7;
  endtask
endmodule
`default_nettype wire

/* rtl/iad_decode.sv */
// ISA address decode, DMA routing and interrupt routing for a data-acquisition board.
// Assumes ISA pins arrive asynchronously; request lines come from on-chip logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module iad_decode
  import iad_pkg::*;
#(
  parameter int NREG = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire iad_isa_pins_t isa_in,
  input wire iad_cfg_t straps,
  input wire logic [7:0] port_c,
  input wire logic ana_irq_req,
  input wire logic dio_irq_req,
  input wire logic [NSTREAM-1:0] dma_req,
  output iad_access_t access,
  output logic [NSTREAM-1:0] dma_ack,
  output logic [NCHAN-1:0] drq_out,
  output logic [NCHAN-1:0] drq_oe,
  output logic [IRQ_W-1:0] irq_out,
  output logic [IRQ_W-1:0] irq_oe
);

  localparam int PIN_W = $bits(iad_isa_pins_t);
  localparam int CFG_W = $bits(iad_cfg_t);
  localparam int SY_W = PIN_W + CFG_W;

  typedef struct packed {
    logic prev_rd_n;
    logic prev_wr_n;
    iad_access_t acc;
    logic [NSTREAM-1:0] ack;
    logic [NCHAN-1:0] drq;
    logic [NCHAN-1:0] drq_en;
    logic [IRQ_W-1:0] irq;
    logic [IRQ_W-1:0] irq_en;
  } iad_state_t;

  initial begin
    if (NREG != (1 << WIN_W)) begin
      $error("iad_decode: register window must be 32 bytes");
    end
  end

  // One-hot channel select from a route code; code 0 leaves the stream unrouted
  function automatic logic [NCHAN-1:0] chan_onehot(input logic [1:0] code);
    logic [NCHAN-1:0] oh;
    oh = '0;
    case (code)
      DMA_CH5: oh = 3'h1;
      DMA_CH6: oh = 3'h2;
      DMA_CH7: oh = 3'h4;
      default: oh = '0;
    endcase
    return oh;
  endfunction

  // One-hot level select, kept only if the level is wired for that circuit
  function automatic logic [IRQ_W-1:0] irq_onehot(input logic [3:0] lvl,
                                                  input logic [IRQ_W-1:0] ok);
    logic [IRQ_W-1:0] oh;
    oh = '0;
    oh[lvl] = 1'b1;
    return oh & ok;
  endfunction

  // Strobes idle high and the straps read as all zeros, so the
  // synchroniser outputs are offset by these constants during reset.
  localparam iad_isa_pins_t PIN_IDLE = '{addr: '0, iord_n: 1'b1, iowr_n: 1'b1,
                                         aen: 1'b1, dack_n: '1};
  localparam logic [SY_W-1:0] SY_RST = {PIN_IDLE, {CFG_W{1'b0}}};

  logic [SY_W-1:0] sy_raw;
  iad_isa_pins_t sy_pins;
  iad_cfg_t sy_cfg;

  iad_sync2 #(
    .W(SY_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .d({isa_in ^ PIN_IDLE, straps}),
    .rst_val(SY_RST),
    .q(sy_raw)
  );

  assign sy_pins = iad_isa_pins_t'(sy_raw[SY_W-1:CFG_W]);
  assign sy_cfg = iad_cfg_t'(sy_raw[CFG_W-1:0]);

  iad_state_t st_reg;
  iad_state_t st_next;

  logic win_hit;
  logic cpu_cycle;
  logic rd_fall;
  logic wr_fall;
  logic dio_gate;
  logic [NSTREAM-1:0][NCHAN-1:0] route;
  logic [IRQ_W-1:0] ana_line;
  logic [IRQ_W-1:0] dio_line;

  always_comb begin
    st_next = st_reg;
    win_hit = 1'b0;
    cpu_cycle = 1'b0;
    rd_fall = 1'b0;
    wr_fall = 1'b0;
    dio_gate = 1'b0;
    route = '0;
    ana_line = '0;
    dio_line = '0;

    // The switch reads high on its OFF side, so the bit compares directly
    win_hit = (sy_pins.addr[ADDR_W-1:WIN_LO] == sy_cfg.base_address_switch);
    // AEN high or any acknowledge low means the DMA controller drives the address
    cpu_cycle = !sy_pins.aen && (&sy_pins.dack_n);
    rd_fall = st_reg.prev_rd_n && !sy_pins.iord_n;
    wr_fall = st_reg.prev_wr_n && !sy_pins.iowr_n;

    st_next.prev_rd_n = sy_pins.iord_n;
    st_next.prev_wr_n = sy_pins.iowr_n;
    st_next.acc.sel = win_hit && cpu_cycle;
    st_next.acc.rd_stb = win_hit && cpu_cycle && rd_fall;
    st_next.acc.wr_stb = win_hit && cpu_cycle && wr_fall;
    if (win_hit && cpu_cycle) begin
      st_next.acc.reg_index = sy_pins.addr[WIN_LO-1:0];
    end

    // A single code per stream drives both request and acknowledge
    for (int s = 0; s < NSTREAM; s++) begin
      route[s] = chan_onehot(sy_cfg.dma_route_jumpers[s]);
    end
    st_next.drq = '0;
    st_next.drq_en = '0;
    for (int s = 0; s < NSTREAM; s++) begin
      st_next.drq_en = st_next.drq_en | route[s];
      if (dma_req[s]) begin
        st_next.drq = st_next.drq | route[s];
      end
      st_next.ack[s] = |(route[s] & ~sy_pins.dack_n);
    end

    // Tristate drive: enable only the jumpered line, leave the rest to other cards
    dio_gate = port_c[sy_cfg.dio_irq_gate_jumper];
    ana_line = irq_onehot(sy_cfg.ana_irq_jumper, ANA_IRQ_OK);
    dio_line = dio_gate ? irq_onehot(sy_cfg.dio_irq_jumper, DIO_IRQ_OK) : '0;
    st_next.irq_en = ana_line | dio_line;
    st_next.irq = (ana_irq_req ? ana_line : '0) | (dio_irq_req ? dio_line : '0);

    if (!ce) begin
      st_next = st_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg.prev_rd_n <= 1'b1;
      st_reg.prev_wr_n <= 1'b1;
      st_reg.acc <= '0;
      st_reg.ack <= '0;
      st_reg.drq <= RST_DRQ;
      st_reg.drq_en <= RST_DRQ;
      st_reg.irq <= RST_IRQ;
      st_reg.irq_en <= RST_IRQ;
    end else begin
      st_reg <= st_next;
    end
  end

  assign access = st_reg.acc;
  assign dma_ack = st_reg.ack;
  assign drq_out = st_reg.drq;
  assign drq_oe = st_reg.drq_en;
  assign irq_out = st_reg.irq;
  assign irq_oe = st_reg.irq_en;

endmodule
`default_nettype wire

/* rtl/iad_pkg.sv */
// Shared constants and carrier types for the ISA address decode front end.
// Assumes a 10-bit ISA I/O address and jumper/switch straps presented as plain levels.
package iad_pkg;

  localparam int ADDR_W = 10;
  localparam int WIN_LO = 5;
  localparam int WIN_W = 5;
  localparam int IRQ_W = 16;
  localparam int NCHAN = 3;
  localparam int NSTREAM = 2;

  // Factory straps: base hex 220, streams on channels 6 and 7, levels 10 and 5, gate bit 4
  localparam logic [4:0] DEF_BASE_SW = 5'h11;
  localparam logic [ADDR_W-1:0] DEF_BASE_ADDR = 10'h220;
  localparam logic [ADDR_W-1:0] DEF_LAST_ADDR = 10'h23F;
  localparam logic [1:0] DMA_NONE = 2'h0;
  localparam logic [1:0] DMA_CH5 = 2'h1;
  localparam logic [1:0] DMA_CH6 = 2'h2;
  localparam logic [1:0] DMA_CH7 = 2'h3;
  localparam logic [1:0] DEF_DMA1 = DMA_CH6;
  localparam logic [1:0] DEF_DMA2 = DMA_CH7;
  localparam logic [3:0] DEF_ANA_IRQ = 4'hA;
  localparam logic [3:0] DEF_DIO_IRQ = 4'h5;
  localparam logic [2:0] DEF_GATE_BIT = 3'h4;

  // Levels each circuit may drive: 3-7,9-12,14,15 and 3-7,9
  localparam logic [IRQ_W-1:0] ANA_IRQ_OK = 16'hDEF8;
  localparam logic [IRQ_W-1:0] DIO_IRQ_OK = 16'h02F8;

  localparam logic [IRQ_W-1:0] RST_IRQ = 16'h0000;
  localparam logic [NCHAN-1:0] RST_DRQ = 3'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic iord_n;
    logic iowr_n;
    logic aen;
    logic [NCHAN-1:0] dack_n;
  } iad_isa_pins_t;

  typedef struct packed {
    logic [WIN_W-1:0] base_address_switch;
    logic [NSTREAM-1:0][1:0] dma_route_jumpers;
    logic [3:0] ana_irq_jumper;
    logic [3:0] dio_irq_jumper;
    logic [2:0] dio_irq_gate_jumper;
  } iad_cfg_t;

  typedef struct packed {
    logic sel;
    logic [WIN_W-1:0] reg_index;
    logic rd_stb;
    logic wr_stb;
  } iad_access_t;

endpackage

/* rtl/iad_sync2.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is independent; multi-bit values must be stable while sampled.
`timescale 1ns/1ps
`default_nettype none
module iad_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iad_sync_st_t;

  iad_sync_st_t st_reg;
  iad_sync_st_t st_next;

  initial begin
    if (W < 1) begin
      $error("iad_sync2: width must be at least one");
    end
  end

  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
    end
  end

  // Reset takes zero; rst_val is XORed onto the second stage output, so q reads rst_val during reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2 ^ rst_val;

endmodule
`default_nettype wire
